// *** rtl/adc_ctrl.sv ***
// Conversion sequencer, input selection and AXI4-Lite register file
`default_nettype none
module adc_ctrl #(
    parameter int addr_width = 8,
    parameter int sample_width = 24,
    parameter int osc_div_n = adc_ctrl_pkg::osc_div_normal,
    parameter int osc_div_t = adc_ctrl_pkg::osc_div_turbo
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [addr_width-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [addr_width-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [sample_width-1:0] sample_data,
    output logic [2:0] pos_route,
    output logic [2:0] neg_route,
    output logic neg_to_supply_switch,
    output logic amp_enable,
    output logic [2:0] gain_applied,
    output logic [2:0] exc1_route,
    output logic [2:0] exc2_route,
    output logic mod_clk_en,
    output logic conv_start,
    output logic conv_active,
    output logic data_ready
);
    localparam logic [1:0] resp_okay = 2'b00;
    localparam logic [1:0] resp_slverr = 2'b10;

    // Modulator clocks per conversion for a rate code
    function automatic logic [13:0] conv_len(input logic [2:0] rate);
        case (rate)
            3'd0: conv_len = adc_ctrl_pkg::conv_len_r0;
            3'd1: conv_len = adc_ctrl_pkg::conv_len_r1;
            3'd2: conv_len = adc_ctrl_pkg::conv_len_r2;
            3'd3: conv_len = adc_ctrl_pkg::conv_len_r3;
            3'd4: conv_len = adc_ctrl_pkg::conv_len_r4;
            3'd5: conv_len = adc_ctrl_pkg::conv_len_r5;
            default: conv_len = adc_ctrl_pkg::conv_len_r6;
        endcase
    endfunction

    // Positive and negative routing for a selection code
    function automatic logic [5:0] sel_route(input logic [3:0] sel);
        case (sel)
            4'h0: sel_route = {3'd0, 3'd1};
            4'h1: sel_route = {3'd0, 3'd2};
            4'h2: sel_route = {3'd0, 3'd3};
            4'h3: sel_route = {3'd1, 3'd2};
            4'h4: sel_route = {3'd1, 3'd3};
            4'h5: sel_route = {3'd2, 3'd3};
            4'h6: sel_route = {3'd1, 3'd0};
            4'h7: sel_route = {3'd3, 3'd2};
            4'h8: sel_route = {3'd0, adc_ctrl_pkg::route_neg_supply};
            4'h9: sel_route = {3'd1, adc_ctrl_pkg::route_neg_supply};
            4'ha: sel_route = {3'd2, adc_ctrl_pkg::route_neg_supply};
            4'hb: sel_route = {3'd3, adc_ctrl_pkg::route_neg_supply};
            4'hc: sel_route = {adc_ctrl_pkg::route_ref_mon, adc_ctrl_pkg::route_ref_mon};
            4'hd: sel_route = {adc_ctrl_pkg::route_supply_mon, adc_ctrl_pkg::route_supply_mon};
            default: sel_route = {adc_ctrl_pkg::route_mid, adc_ctrl_pkg::route_mid};
        endcase
    endfunction

    logic [7:0] cfg0;
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic [7:0] cfg3;
    logic [7:0] cfg4;
    adc_ctrl_pkg::state_e state;
    adc_ctrl_pkg::state_e next_state;
    logic [6:0] osc_cnt;
    logic [1:0] mod_cnt;
    logic [13:0] mod_count;
    logic [13:0] conv_target;
    logic cmd_err;
    logic aw_held;
    logic w_held;
    logic [addr_width-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [sample_width-1:0] result;

    // Register decode
    wire [3:0] sel_field = cfg0[adc_ctrl_pkg::sel_lsb +: 4];
    wire [2:0] gain_field = cfg0[adc_ctrl_pkg::gain_lsb +: 3];
    wire bypass_field = cfg0[adc_ctrl_pkg::bypass_bit];
    wire [2:0] rate_field = cfg1[adc_ctrl_pkg::rate_lsb +: 3];
    wire turbo = cfg1[adc_ctrl_pkg::turbo_bit];
    wire continuous = cfg1[adc_ctrl_pkg::cont_bit];
    wire single_ended = sel_field[3:2] == 2'b10;
    wire [2:0] gain_eff = (single_ended && gain_field > 3'd2) ? 3'd2 : gain_field;
    wire amp_on = !(single_ended || bypass_field);
    wire [5:0] route_pair = sel_route(sel_field);

    // Oscillator and modulator enables
    wire [6:0] osc_last = turbo ? 7'(osc_div_t - 1) : 7'(osc_div_n - 1);
    wire osc_tick = osc_cnt >= osc_last;
    wire mod_tick = osc_tick && mod_cnt == 2'(adc_ctrl_pkg::mod_div - 1);

    // Bus decode
    wire wr_fire = aw_held && w_held && !s_axi_bvalid;
    wire [7:0] wr_off = 8'(aw_addr);
    wire [7:0] rd_off = 8'(s_axi_araddr);
    wire wr_lane = w_strb[0];
    wire wr_cfg0 = wr_fire && wr_lane && wr_off == adc_ctrl_pkg::off_cfg0;
    wire wr_cfg1 = wr_fire && wr_lane && wr_off == adc_ctrl_pkg::off_cfg1;
    wire wr_cfg2 = wr_fire && wr_lane && wr_off == adc_ctrl_pkg::off_cfg2;
    wire wr_cfg3 = wr_fire && wr_lane && wr_off == adc_ctrl_pkg::off_cfg3;
    wire wr_cfg4 = wr_fire && wr_lane && wr_off == adc_ctrl_pkg::off_cfg4;
    wire wr_cmd = wr_fire && wr_lane && wr_off == adc_ctrl_pkg::off_cmd;
    wire wr_known = wr_off <= adc_ctrl_pkg::off_cmd && wr_off[1:0] == 2'b00;
    wire [7:0] cmd_code = w_data[7:0];
    wire do_reset = wr_cmd && cmd_code == adc_ctrl_pkg::cmd_reset;
    wire do_start = wr_cmd && cmd_code == adc_ctrl_pkg::cmd_start;
    wire do_pdown = wr_cmd && cmd_code == adc_ctrl_pkg::cmd_powerdown;
    wire cmd_valid = cmd_code >= adc_ctrl_pkg::cmd_reset
        && cmd_code <= adc_ctrl_pkg::cmd_write_reg;
    wire rd_fire = s_axi_arvalid && s_axi_arready;
    wire rd_result = rd_fire && rd_off == adc_ctrl_pkg::off_result;
    wire rd_known = rd_off <= adc_ctrl_pkg::off_status && rd_off[1:0] == 2'b00;

    // Conversion sequencing
    wire conv_done = state == adc_ctrl_pkg::st_convert && mod_tick
        && mod_count == conv_target - 14'd1;
    wire begin_conv = (do_start && !do_pdown) || (conv_done && continuous);

    always_comb begin
        next_state = state;
        case (state)
            adc_ctrl_pkg::st_idle: begin
                if (do_start) begin
                    next_state = adc_ctrl_pkg::st_convert;
                end
            end
            adc_ctrl_pkg::st_convert: begin
                if (do_start) begin
                    next_state = adc_ctrl_pkg::st_convert;
                end else if (conv_done && !continuous) begin
                    next_state = adc_ctrl_pkg::st_idle;
                end
            end
            adc_ctrl_pkg::st_powerdown: begin
                if (do_start) begin
                    next_state = adc_ctrl_pkg::st_convert;
                end
            end
            default: next_state = adc_ctrl_pkg::st_idle;
        endcase
        if (do_pdown) begin
            next_state = adc_ctrl_pkg::st_powerdown;
        end
        if (do_reset) begin
            next_state = adc_ctrl_pkg::st_idle;
        end
    end

    wire [31:0] rd_mux =
        rd_off == adc_ctrl_pkg::off_cfg0 ? {24'h0, cfg0} :
        rd_off == adc_ctrl_pkg::off_cfg1 ? {24'h0, cfg1} :
        rd_off == adc_ctrl_pkg::off_cfg2 ? {24'h0, cfg2} :
        rd_off == adc_ctrl_pkg::off_cfg3 ? {24'h0, cfg3} :
        rd_off == adc_ctrl_pkg::off_cfg4 ? {24'h0, cfg4} :
        rd_off == adc_ctrl_pkg::off_result ? 32'(result) :
        rd_off == adc_ctrl_pkg::off_status ? {26'h0, cmd_err, data_ready, 1'b0, state} :
        32'h0;

    result_buffer #(
        .width(sample_width)
    ) u_result (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_en(conv_done),
        .wr_data(sample_data),
        .rd_data(result)
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_cnt <= 7'h0;
            mod_cnt <= 2'h0;
            mod_clk_en <= 1'b0;
        end else begin
            osc_cnt <= osc_tick ? 7'h0 : osc_cnt + 7'h1;
            mod_cnt <= osc_tick ? mod_cnt + 2'h1 : mod_cnt;
            mod_clk_en <= mod_tick && state == adc_ctrl_pkg::st_convert
                && next_state == adc_ctrl_pkg::st_convert;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || do_reset) begin
            cfg0 <= adc_ctrl_pkg::cfg_reset;
            cfg1 <= adc_ctrl_pkg::cfg_reset;
            cfg2 <= adc_ctrl_pkg::cfg_reset;
            cfg3 <= adc_ctrl_pkg::cfg_reset;
            cfg4 <= adc_ctrl_pkg::cfg_reset;
        end else begin
            cfg0 <= wr_cfg0 ? w_data[7:0] : cfg0;
            cfg1 <= wr_cfg1 ? w_data[7:0] : cfg1;
            cfg2 <= wr_cfg2 ? w_data[7:0] : cfg2;
            cfg3 <= wr_cfg3 ? w_data[7:0] : cfg3;
            cfg4 <= wr_cfg4 ? w_data[7:0] : cfg4;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= adc_ctrl_pkg::st_idle;
            mod_count <= 14'h0;
            conv_target <= adc_ctrl_pkg::conv_len_r6;
            conv_start <= 1'b0;
            conv_active <= 1'b0;
        end else begin
            state <= next_state;
            conv_start <= begin_conv && !do_reset;
            conv_active <= next_state == adc_ctrl_pkg::st_convert;
            if (begin_conv) begin
                mod_count <= 14'h0;
                conv_target <= conv_len(rate_field);
            end else if (mod_tick && state == adc_ctrl_pkg::st_convert) begin
                mod_count <= mod_count + 14'h1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pos_route <= adc_ctrl_pkg::route_mid;
            neg_route <= adc_ctrl_pkg::route_mid;
            neg_to_supply_switch <= 1'b0;
            amp_enable <= 1'b1;
            gain_applied <= 3'h0;
        end else if (begin_conv) begin
            pos_route <= route_pair[5:3];
            neg_route <= route_pair[2:0];
            neg_to_supply_switch <= single_ended;
            amp_enable <= amp_on;
            gain_applied <= gain_eff;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            exc1_route <= 3'h0;
            exc2_route <= 3'h0;
        end else begin
            exc1_route <= cfg2[adc_ctrl_pkg::exc1_lsb +: 3];
            exc2_route <= cfg2[adc_ctrl_pkg::exc2_lsb +: 3];
        end
    end

    // Ready flag: completion wins over a clearing read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_ready <= 1'b0;
            cmd_err <= 1'b0;
        end else begin
            data_ready <= conv_done || (data_ready && !rd_result && !do_reset);
            cmd_err <= (wr_cmd && !cmd_valid) || (cmd_err && !wr_cmd);
        end
    end

    // AXI4-Lite write channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= resp_okay;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? resp_okay : resp_slverr;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // AXI4-Lite read channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= resp_okay;
        end else if (rd_fire) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_known ? resp_okay : resp_slverr;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// *** rtl/adc_ctrl_pkg.sv ***
// Shared constants for the converter control block
`default_nettype none
package adc_ctrl_pkg;
    // Register byte offsets
    localparam logic [7:0] off_cfg0 = 8'h00;
    localparam logic [7:0] off_cfg1 = 8'h04;
    localparam logic [7:0] off_cfg2 = 8'h08;
    localparam logic [7:0] off_cfg3 = 8'h0c;
    localparam logic [7:0] off_cfg4 = 8'h10;
    localparam logic [7:0] off_cmd = 8'h14;
    localparam logic [7:0] off_result = 8'h18;
    localparam logic [7:0] off_status = 8'h1c;
    // Field positions
    localparam int sel_lsb = 4;
    localparam int gain_lsb = 1;
    localparam int bypass_bit = 0;
    localparam int rate_lsb = 5;
    localparam int turbo_bit = 4;
    localparam int cont_bit = 3;
    localparam int exc1_lsb = 5;
    localparam int exc2_lsb = 2;
    // Reset values
    localparam logic [7:0] cfg_reset = 8'h00;
    // Commands
    localparam logic [7:0] cmd_reset = 8'h01;
    localparam logic [7:0] cmd_start = 8'h02;
    localparam logic [7:0] cmd_powerdown = 8'h03;
    localparam logic [7:0] cmd_read_data = 8'h04;
    localparam logic [7:0] cmd_read_reg = 8'h05;
    localparam logic [7:0] cmd_write_reg = 8'h06;
    // Timing
    localparam int clk_khz = 100000;
    localparam int osc_normal_khz = 1024;
    localparam int osc_turbo_khz = 2048;
    localparam int osc_div_normal = (clk_khz + osc_normal_khz / 2) / osc_normal_khz;
    localparam int osc_div_turbo = (clk_khz + osc_turbo_khz / 2) / osc_turbo_khz;
    localparam int mod_div = 4;
    // Modulator clocks per conversion, by rate code
    localparam logic [13:0] conv_len_r0 = 14'h3200;
    localparam logic [13:0] conv_len_r1 = 14'h1639;
    localparam logic [13:0] conv_len_r2 = 14'h0b1c;
    localparam logic [13:0] conv_len_r3 = 14'h05b7;
    localparam logic [13:0] conv_len_r4 = 14'h0308;
    localparam logic [13:0] conv_len_r5 = 14'h01ab;
    localparam logic [13:0] conv_len_r6 = 14'h0100;
    // Input routing codes for each converter input
    localparam logic [2:0] route_neg_supply = 3'h4;
    localparam logic [2:0] route_ref_mon = 3'h5;
    localparam logic [2:0] route_supply_mon = 3'h6;
    localparam logic [2:0] route_mid = 3'h7;
    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_convert = 3'b010,
        st_powerdown = 3'b100
    } state_e;
endpackage
`default_nettype wire

// *** rtl/result_buffer.sv ***
// Result holding register, replaced whole in one edge
`default_nettype none
module result_buffer #(
    parameter int width = 24
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic wr_en,
    input wire logic [width-1:0] wr_data,
    output logic [width-1:0] rd_data
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_data <= '0;
        end else if (wr_en) begin
            rd_data <= wr_data;
        end
    end
endmodule
`default_nettype wire

// *** tb/adc_ctrl_chk.sv ***
// Port assertions for the converter control block
`default_nettype none
module adc_ctrl_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [2:0] pos_route,
    input wire logic [2:0] neg_route,
    input wire logic neg_to_supply_switch,
    input wire logic amp_enable,
    input wire logic [2:0] gain_applied,
    input wire logic mod_clk_en,
    input wire logic conv_start,
    input wire logic conv_active
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_rvalid_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read data dropped early");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_start_active: assert property (conv_start |-> conv_active)
        else $error("start without conversion");
    a_tick_in_conv: assert property (mod_clk_en |-> conv_active)
        else $error("modulator tick while idle");
    a_tick_spacing: assert property (mod_clk_en |=> !mod_clk_en [*3])
        else $error("modulator ticks too close");
    a_se_switch: assert property (neg_to_supply_switch |->
        neg_route == adc_ctrl_pkg::route_neg_supply)
        else $error("switch without supply route");
    a_se_clamp: assert property (neg_to_supply_switch |-> !amp_enable
        && gain_applied <= 3'h2)
        else $error("amplifier not bypassed or gain unclamped");
    a_route_latched: assert property ($changed(pos_route) || $changed(neg_route)
        |-> conv_start)
        else $error("route changed outside conversion start");
    c_start_se: cover property (conv_start && neg_to_supply_switch);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_conv_end: cover property ($fell(conv_active));
endmodule
bind adc_ctrl adc_ctrl_chk i_adc_ctrl_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .pos_route(pos_route), .neg_route(neg_route), .neg_to_supply_switch(neg_to_supply_switch),
    .amp_enable(amp_enable), .gain_applied(gain_applied), .mod_clk_en(mod_clk_en),
    .conv_start(conv_start), .conv_active(conv_active));
`default_nettype wire

// *** tb/adc_ctrl_tb_top.sv ***
// Self-checking bench for the converter control block
`default_nettype none
module adc_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int divn = 2;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [23:0] sample_data;
    logic [2:0] pos_route, neg_route, gain_applied, exc1_route, exc2_route;
    logic neg_sw, amp_enable, mod_clk_en, conv_start, conv_active, data_ready;
    int fail_count = 0;
    int num_checks = 0;
    int starts = 0;
    always #5 aclk = ~aclk;
    // Counts conversion starts so a one-cycle pulse is never missed
    always @(posedge aclk) begin
        if (conv_start) begin
            starts <= starts + 1;
        end
    end
    adc_ctrl #(.osc_div_n(divn), .osc_div_t(1)) i_adc_ctrl (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .sample_data(sample_data), .pos_route(pos_route), .neg_route(neg_route),
        .neg_to_supply_switch(neg_sw), .amp_enable(amp_enable), .gain_applied(gain_applied),
        .exc1_route(exc1_route), .exc2_route(exc2_route), .mod_clk_en(mod_clk_en),
        .conv_start(conv_start), .conv_active(conv_active), .data_ready(data_ready));
    filter_model i_filter_model (.aclk(aclk), .aresetn(aresetn), .conv_start(conv_start),
        .sample_data(sample_data));
    task automatic conclude();
        if (fail_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw || w) begin
            @(posedge aclk);
            if (awready) aw = 1'b0;
            if (wready) w = 1'b0;
            if (!aw) awvalid <= 1'b0;
            if (!w) wvalid <= 1'b0;
        end
        while (!bvalid) @(posedge aclk);
        bready <= 1'b0;
        chk(bresp, er);
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
        chk(rdata, ed);
        chk(rresp, er);
    endtask
    task automatic t_reset();
        chk({awready, wready, arready, bvalid, rvalid}, 5'b11100);
        chk({pos_route, neg_route}, 6'o77);
        axr(adc_ctrl_pkg::off_status, 32'h1, 2'b00);
    endtask
    task automatic t_regs();
        logic [7:0] offs [5];
        offs = '{adc_ctrl_pkg::off_cfg0, adc_ctrl_pkg::off_cfg1, adc_ctrl_pkg::off_cfg2,
            adc_ctrl_pkg::off_cfg3, adc_ctrl_pkg::off_cfg4};
        for (int i = 0; i < 5; i++) axw(offs[i], 32'h12345600 + 8'h3c + i, 2'b00);
        for (int i = 0; i < 5; i++) axr(offs[i], 32'h3c + i, 2'b00);
        chk({exc1_route, exc2_route}, 6'o17);
        axr(adc_ctrl_pkg::off_cmd, 32'h0, 2'b00);
        axw(8'h20, 32'h1, 2'b10);
        axw(8'h02, 32'h1, 2'b10);
        axr(8'h20, 32'h0, 2'b10);
        axw(adc_ctrl_pkg::off_cmd, adc_ctrl_pkg::cmd_reset, 2'b00);
        for (int i = 0; i < 5; i++) axr(offs[i], 32'h0, 2'b00);
        axw(adc_ctrl_pkg::off_cmd, 32'h07, 2'b00);
        axr(adc_ctrl_pkg::off_status, 32'h21, 2'b00);
        for (int c = 4; c < 7; c++) axw(adc_ctrl_pkg::off_cmd, c, 2'b00);
        axr(adc_ctrl_pkg::off_status, 32'h01, 2'b00);
    endtask
    task automatic t_single();
        int n;
        int s;
        logic [23:0] exp;
        axw(adc_ctrl_pkg::off_cfg0, 32'h8e, 2'b00);
        axw(adc_ctrl_pkg::off_cfg1, 32'hc0, 2'b00);
        s = starts;
        axw(adc_ctrl_pkg::off_cmd, adc_ctrl_pkg::cmd_start, 2'b00);
        while (starts == s) @(posedge aclk);
        chk({pos_route, neg_route, neg_sw}, 7'b000_100_1);
        chk({amp_enable, gain_applied}, 4'h2);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (!data_ready);
        exp = sample_data;
        chk(n >= 255 * 4 * divn - 2 && n <= 256 * 4 * divn + 2, 1'b1);
        chk(conv_active, 1'b0);
        chk(starts, s + 1);
        axr(adc_ctrl_pkg::off_status, 32'h11, 2'b00);
        axr(adc_ctrl_pkg::off_result, exp, 2'b00);
        axr(adc_ctrl_pkg::off_status, 32'h01, 2'b00);
        // Monitor selections, then a start that restarts a running conversion
        axw(adc_ctrl_pkg::off_cfg0, 32'hc0, 2'b00);
        axw(adc_ctrl_pkg::off_cmd, adc_ctrl_pkg::cmd_start, 2'b00);
        while (starts == s + 1) @(posedge aclk);
        chk(pos_route, adc_ctrl_pkg::route_ref_mon);
        chk(neg_route, adc_ctrl_pkg::route_ref_mon);
        chk({neg_sw, amp_enable}, 2'b01);
        axw(adc_ctrl_pkg::off_cfg0, 32'hd0, 2'b00);
        chk(pos_route, adc_ctrl_pkg::route_ref_mon);
        axw(adc_ctrl_pkg::off_cmd, adc_ctrl_pkg::cmd_start, 2'b00);
        while (starts == s + 2) @(posedge aclk);
        chk(pos_route, adc_ctrl_pkg::route_supply_mon);
        chk(neg_route, adc_ctrl_pkg::route_supply_mon);
        chk(conv_active, 1'b1);
        axw(adc_ctrl_pkg::off_cmd, adc_ctrl_pkg::cmd_reset, 2'b00);
        chk(conv_active, 1'b0);
        axr(adc_ctrl_pkg::off_status, 32'h01, 2'b00);
    endtask
    task automatic t_cont();
        int n;
        int s;
        logic [23:0] exp;
        logic [2:0] pr;
        axw(adc_ctrl_pkg::off_cfg0, 32'h12, 2'b00);
        axw(adc_ctrl_pkg::off_cfg1, 32'hd8, 2'b00);
        s = starts;
        axw(adc_ctrl_pkg::off_cmd, adc_ctrl_pkg::cmd_start, 2'b00);
        while (starts == s) @(posedge aclk);
        chk({amp_enable, gain_applied, neg_sw}, 5'b1_001_0);
        pr = pos_route;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (!conv_start);
        exp = sample_data;
        chk(data_ready, 1'b1);
        chk(n >= 255 * 4 - 2 && n <= 256 * 4 + 2, 1'b1);
        axw(adc_ctrl_pkg::off_cfg0, 32'h9e, 2'b00);
        chk(pos_route, pr);
        axr(adc_ctrl_pkg::off_result, exp, 2'b00);
        do @(posedge aclk); while (!conv_start);
        chk(neg_route, adc_ctrl_pkg::route_neg_supply);
        chk({neg_sw, amp_enable, gain_applied}, 5'b1_0_010);
        axw(adc_ctrl_pkg::off_cmd, adc_ctrl_pkg::cmd_powerdown, 2'b00);
        chk(conv_active, 1'b0);
        axr(adc_ctrl_pkg::off_status, 32'h14, 2'b00);
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_regs();
        t_single();
        t_cont();
        repeat (4) @(posedge aclk);
        conclude();
    end
    initial begin
        #300us;
        fail_count++;
        conclude();
    end
endmodule
`default_nettype wire

// *** tb/filter_model.sv ***
// Behavioural digital filter output feeding sample words
`default_nettype none
module filter_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic conv_start,
    output logic [23:0] sample_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // New word for each conversion, so a stale buffer is visible
    always_ff @(posedge aclk) begin
        if (!aresetn)
            sample_data <= 24'h5a0000;
        else if (conv_start)
            sample_data <= sample_data + 24'h000013;
    end
endmodule
`default_nettype wire
